/* include/fppc_pkg.sv */
// Operation
// - Oscillator runs at nominal 55 kHz; outside burst each period begins one switching cycle.
// - Switching period is dithered continuously within plus and minus four percent.
// - On leaving lockout, the peak limit ramps from zero to 0.75V over 4ms.
// - Every restart, including automatic recovery, repeats the full soft-start ramp.
// - Feedback below burst threshold enters burst control at nominal 22 kHz rate.
// - In burst, pulse only when supply is low and feedback requests on.
// - Current-limit comparator is ignored during blanking at the start of on time.
// - After blanking, sensed current reaching feedback level ends the on pulse.
// - Plateau is sampled during flyback only after about 2us from its start.
// - Eight successive plateaus above 2.5V declare output overvoltage and auto-recovery.
// - A plateau below threshold before eight clears the counter, no fault.
// - Feedback above power limit longer than debounce time shuts down switching.
// - After overload, resume only after supply drops below lockout, then fresh start.
// - Over-temperature or open current-sense input turns the power switch off.
// - Supply above 29V holds the switch off until supply falls below 8V.
// - After supply overvoltage releases, run the complete power-on restart sequence.
// - Leading-edge blanking lasts about 270 ns from the start of each pulse.
// - Overload debounce is about 50 ms of continuous power-limit indication.
package fppc_pkg;

    localparam int CLK_HZ = 50_000_000;
    localparam int CLK_MHZ = 50;

    localparam int OSC_HZ = 55_000;
    localparam int OSC_CYC = CLK_HZ / OSC_HZ;
    localparam int DITHER_PCT = 4;
    localparam int DITHER_CYC = OSC_CYC * DITHER_PCT / 100;
    localparam int OSC_W = 10;
    localparam int DITHER_W = 7;

    localparam int MAX_DUTY_PCT = 75;
    localparam int MAX_ON_CYC = OSC_CYC * MAX_DUTY_PCT / 100;

    localparam int BURST_HZ = 22_000;
    localparam int BURST_CYC = CLK_HZ / BURST_HZ;
    localparam int BURST_W = 12;

    localparam int BLANK_NS = 270;
    localparam int BLANK_CYC = (BLANK_NS * CLK_MHZ + 999) / 1000;

    localparam int PLATEAU_NS = 2000;
    localparam int PLATEAU_CYC = (PLATEAU_NS * CLK_MHZ + 999) / 1000;
    localparam int PLATEAU_W = 7;

    localparam int OVP_EVENTS = 8;
    localparam int OVP_W = 4;

    localparam int SS_MS = 4;
    localparam int SS_CYC = CLK_HZ / 1000 * SS_MS;
    localparam int SS_LEVEL_W = 8;
    localparam logic [SS_LEVEL_W-1:0] SS_LEVEL_MAX = 8'hFF;
    localparam int SS_CNT_W = 18;

    localparam int OLP_MS = 50;
    localparam int OLP_CYC = CLK_HZ / 1000 * OLP_MS;
    localparam int OLP_W = 22;

    typedef enum logic [1:0] {
        FPPC_LOCKOUT = 2'b00,
        FPPC_RUN = 2'b01,
        FPPC_FAULT = 2'b10
    } fppc_state_t;

    typedef enum logic [2:0] {
        FPPC_F_NONE = 3'b000,
        FPPC_F_OUT_OVP = 3'b001,
        FPPC_F_OVERLOAD = 3'b010,
        FPPC_F_OVER_TEMP = 3'b011,
        FPPC_F_SENSE_OPEN = 3'b100,
        FPPC_F_SUPPLY_OVP = 3'b101
    } fppc_fault_t;

endpackage

/* rtl/fppc_osc.sv */
`timescale 1ns/10ps
module fppc_osc
(
    // Clock and reset.
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Cycle marker.
    output logic period_start_o
);

    localparam logic [fppc_pkg::OSC_W-1:0] BASE = fppc_pkg::OSC_W'(fppc_pkg::OSC_CYC);
    localparam logic signed [fppc_pkg::DITHER_W-1:0] SPAN = fppc_pkg::DITHER_W'(fppc_pkg::DITHER_CYC);

    logic [fppc_pkg::OSC_W-1:0] cnt_reg;
    logic signed [fppc_pkg::DITHER_W-1:0] offs_reg;
    logic up_reg;
    logic [fppc_pkg::OSC_W-1:0] period_len;
    logic wrap;

    ////////////////////////////////////////////////////////////////////////////////
    // A triangle sweep of one cycle per period keeps the spectrum flat across the band.
    assign period_len = fppc_pkg::OSC_W'($signed({1'b0, BASE}) + offs_reg);
    assign wrap = (cnt_reg == period_len - 10'h001);
    assign period_start_o = wrap;

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            cnt_reg <= 10'h000;
            offs_reg <= 7'h00;
            up_reg <= 1'b1;
        end
        else
        begin
            cnt_reg <= wrap ? 10'h000 : cnt_reg + 10'h001;
            if (wrap)
            begin
                offs_reg <= up_reg ? offs_reg + 7'h01 : offs_reg - 7'h01;
                if (up_reg && offs_reg == SPAN - 7'h01)
                    up_reg <= 1'b0;
                else if (!up_reg && offs_reg == -SPAN + 7'h01)
                    up_reg <= 1'b1;
            end
        end
    end

endmodule // fppc_osc

/* rtl/fppc_soft_start.sv */
`timescale 1ns/10ps
module fppc_soft_start
#(
    parameter int SS_CYCLES = fppc_pkg::SS_CYC
)
(
    // Clock and reset.
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Control.
    input wire logic restart_i,
    // Limit level towards the peak-current comparator.
    output logic [fppc_pkg::SS_LEVEL_W-1:0] level_o
);

    localparam int STEP_INT = (SS_CYCLES / 255 < 1) ? 1 : SS_CYCLES / 255;
    localparam logic [fppc_pkg::SS_CNT_W-1:0] STEP = fppc_pkg::SS_CNT_W'(STEP_INT);

    logic [fppc_pkg::SS_CNT_W-1:0] div_reg;
    logic [fppc_pkg::SS_LEVEL_W-1:0] level_reg;
    logic step_en;

    ////////////////////////////////////////////////////////////////////////////////
    // The level climbs one code per step so the full scale is reached after the ramp time.
    assign step_en = (div_reg == STEP - 18'h00001);
    assign level_o = level_reg;

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i || restart_i)
        begin
            div_reg <= 18'h00000;
            level_reg <= 8'h00;
        end
        else
        begin
            div_reg <= step_en ? 18'h00000 : div_reg + 18'h00001;
            if (step_en && level_reg != fppc_pkg::SS_LEVEL_MAX)
                level_reg <= level_reg + 8'h01;
        end
    end

endmodule // fppc_soft_start

/* rtl/fppc_core.sv */
`timescale 1ns/10ps
module fppc_core
#(
    parameter int SS_CYCLES = fppc_pkg::SS_CYC,
    parameter int OLP_CYCLES = fppc_pkg::OLP_CYC
)
(
    // Clock and reset.
    input wire logic sys_clk_i,
    input wire logic rst_i,

    // Supply comparators.
    input wire logic supply_above_exit_i,
    input wire logic supply_below_lockout_i,
    input wire logic supply_ovp_i,
    input wire logic supply_below_burst_i,

    // Feedback comparators.
    input wire logic fb_below_burst_i,
    input wire logic fb_on_request_i,
    input wire logic fb_above_limit_i,

    // Current sense and protection comparators.
    input wire logic cs_reach_fb_i,
    input wire logic cs_reach_ss_i,
    input wire logic sense_open_i,
    input wire logic over_temp_i,
    input wire logic plateau_above_i,

    // Gate command and status.
    output logic gate_o,
    output logic [fppc_pkg::SS_LEVEL_W-1:0] ss_level_o,
    output logic lockout_o,
    output logic burst_o,
    output logic fault_o,
    output logic [2:0] fault_code_o
);

    localparam logic [fppc_pkg::OSC_W-1:0] MAX_ON = fppc_pkg::OSC_W'(fppc_pkg::MAX_ON_CYC);
    localparam logic [fppc_pkg::OSC_W-1:0] BLANK = fppc_pkg::OSC_W'(fppc_pkg::BLANK_CYC);
    localparam logic [fppc_pkg::BURST_W-1:0] BURST_LEN = fppc_pkg::BURST_W'(fppc_pkg::BURST_CYC);
    localparam logic [fppc_pkg::PLATEAU_W-1:0] PLAT_LEN = fppc_pkg::PLATEAU_W'(fppc_pkg::PLATEAU_CYC);
    localparam logic [fppc_pkg::OVP_W-1:0] OVP_LIM = fppc_pkg::OVP_W'(fppc_pkg::OVP_EVENTS);
    localparam logic [fppc_pkg::OLP_W-1:0] OLP_LIM = fppc_pkg::OLP_W'(OLP_CYCLES);

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations.

    fppc_pkg::fppc_state_t state_reg;
    fppc_pkg::fppc_state_t state_next;
    fppc_pkg::fppc_fault_t fault_reg;
    fppc_pkg::fppc_fault_t fault_hit;

    logic gate_reg;
    logic gate_next;
    logic [fppc_pkg::OSC_W-1:0] on_cnt_reg;
    logic [fppc_pkg::BURST_W-1:0] burst_cnt_reg;
    logic fly_active_reg;
    logic [fppc_pkg::PLATEAU_W-1:0] fly_cnt_reg;
    logic [fppc_pkg::OVP_W-1:0] ovp_cnt_reg;
    logic [fppc_pkg::OLP_W-1:0] olp_cnt_reg;

    logic period_start;
    logic burst_tick;
    logic run;
    logic restart;
    logic past_blank;
    logic cs_stop;
    logic max_on;
    logic start_ok;
    logic sample_now;
    logic ovp_trip;
    logic olp_trip;
    logic any_fault;
    logic run_next;
    logic pulse_end;

    ////////////////////////////////////////////////////////////////////////////////
    // Timing sources.

    fppc_osc u_osc
    (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .period_start_o(period_start)
    );

    fppc_soft_start #(
        .SS_CYCLES(SS_CYCLES)
    ) u_ss
    (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .restart_i(restart),
        .level_o(ss_level_o)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer decode.

    assign run = (state_reg == fppc_pkg::FPPC_RUN);
    assign restart = (state_reg == fppc_pkg::FPPC_LOCKOUT) && (state_next == fppc_pkg::FPPC_RUN);

    assign ovp_trip = (ovp_cnt_reg == OVP_LIM);
    assign olp_trip = (olp_cnt_reg == OLP_LIM);

    // Supply overvoltage is checked first; every fault holds off alike until the supply falls below lockout.
    assign fault_hit = supply_ovp_i ? fppc_pkg::FPPC_F_SUPPLY_OVP :
                       over_temp_i ? fppc_pkg::FPPC_F_OVER_TEMP :
                       sense_open_i ? fppc_pkg::FPPC_F_SENSE_OPEN :
                       ovp_trip ? fppc_pkg::FPPC_F_OUT_OVP :
                       olp_trip ? fppc_pkg::FPPC_F_OVERLOAD :
                       fppc_pkg::FPPC_F_NONE;
    assign any_fault = (fault_hit != fppc_pkg::FPPC_F_NONE);

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            fppc_pkg::FPPC_LOCKOUT:
            begin
                if (supply_above_exit_i && !supply_ovp_i)
                    state_next = fppc_pkg::FPPC_RUN;
            end
            fppc_pkg::FPPC_RUN:
            begin
                if (any_fault)
                    state_next = fppc_pkg::FPPC_FAULT;
                else if (supply_below_lockout_i)
                    state_next = fppc_pkg::FPPC_LOCKOUT;
            end
            fppc_pkg::FPPC_FAULT:
            begin
                // Every fault recovers through lockout, so the restart is a full power-on one.
                if (supply_below_lockout_i)
                    state_next = fppc_pkg::FPPC_LOCKOUT;
            end
            default:
                state_next = fppc_pkg::FPPC_LOCKOUT;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pulse timing decode.

    assign burst_tick = (burst_cnt_reg == BURST_LEN - 12'h001);
    assign past_blank = (on_cnt_reg >= BLANK);
    assign cs_stop = past_blank && (cs_reach_fb_i || cs_reach_ss_i);
    assign max_on = (on_cnt_reg == MAX_ON - 10'h001);

    // Burst pulses start off the oscillator grid, so within run only current or duty may end a pulse.
    assign pulse_end = cs_stop || max_on;
    // Leaving run drops the gate on that same edge, so lockout and fault never see it high.
    assign run_next = (state_next == fppc_pkg::FPPC_RUN);

    // In burst the gate waits for the slower tick and for the supply to sag.
    assign start_ok = fb_below_burst_i
                      ? (burst_tick && supply_below_burst_i && fb_on_request_i)
                      : period_start;

    always_comb
    begin
        gate_next = gate_reg;
        if (!run || !run_next)
            gate_next = 1'b0;
        else if (gate_reg)
        begin
            if (pulse_end)
                gate_next = 1'b0;
        end
        else if (start_ok)
            gate_next = 1'b1;
    end

    assign sample_now = fly_active_reg && !gate_reg && (fly_cnt_reg == PLAT_LEN - 7'h01);

    ////////////////////////////////////////////////////////////////////////////////
    // State and gate registers.

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
            state_reg <= fppc_pkg::FPPC_LOCKOUT;
        else
            state_reg <= state_next;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
            gate_reg <= 1'b0;
        else
            gate_reg <= gate_next;
    end

    // The code survives the hold-off so it can still be read while the supply sags.
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i || restart)
            fault_reg <= fppc_pkg::FPPC_F_NONE;
        else if (run && any_fault)
            fault_reg <= fault_hit;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // On-time and burst counters.

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i || !gate_reg)
            on_cnt_reg <= 10'h000;
        else
            on_cnt_reg <= on_cnt_reg + 10'h001;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i || burst_tick)
            burst_cnt_reg <= 12'h000;
        else
            burst_cnt_reg <= burst_cnt_reg + 12'h001;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Flyback plateau sampling.

    // One sample per gate-off edge, so the debounce count moves at most once a cycle.
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i || gate_next)
        begin
            fly_active_reg <= 1'b0;
            fly_cnt_reg <= 7'h00;
        end
        else if (gate_reg)
        begin
            fly_active_reg <= 1'b1;
            fly_cnt_reg <= 7'h00;
        end
        else if (sample_now)
            fly_active_reg <= 1'b0;
        else if (fly_active_reg)
            fly_cnt_reg <= fly_cnt_reg + 7'h01;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i || !run)
            ovp_cnt_reg <= 4'h0;
        else if (sample_now)
        begin
            if (!plateau_above_i)
                ovp_cnt_reg <= 4'h0;
            else if (!ovp_trip)
                ovp_cnt_reg <= ovp_cnt_reg + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Overload debounce.

    // Any dip below the power limit restarts the wait, so only a continuous overload trips.
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i || !run || !fb_above_limit_i)
            olp_cnt_reg <= 22'h000000;
        else if (!olp_trip)
            olp_cnt_reg <= olp_cnt_reg + 22'h000001;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign gate_o = gate_reg;
    assign lockout_o = (state_reg == fppc_pkg::FPPC_LOCKOUT);
    assign burst_o = run && fb_below_burst_i;
    assign fault_o = (state_reg == fppc_pkg::FPPC_FAULT);
    assign fault_code_o = fault_reg;

endmodule // fppc_core

/* dv/fppc_core_assertions.sv */
`timescale 1ns/10ps
module fppc_core_assertions
#(
    parameter int SS_CYCLES = fppc_pkg::SS_CYC,
    parameter int OLP_CYCLES = fppc_pkg::OLP_CYC
)
(
    // Clock and reset.
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Comparator inputs.
    input wire logic supply_above_exit_i,
    input wire logic supply_below_lockout_i,
    input wire logic supply_ovp_i,
    input wire logic supply_below_burst_i,
    input wire logic fb_below_burst_i,
    input wire logic fb_on_request_i,
    input wire logic fb_above_limit_i,
    input wire logic cs_reach_fb_i,
    input wire logic cs_reach_ss_i,
    input wire logic sense_open_i,
    input wire logic over_temp_i,
    input wire logic plateau_above_i,
    // Core outputs.
    input wire logic gate_o,
    input wire logic [fppc_pkg::SS_LEVEL_W-1:0] ss_level_o,
    input wire logic lockout_o,
    input wire logic burst_o,
    input wire logic fault_o,
    input wire logic [2:0] fault_code_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);

    ////////////////////////////////////////////////////////////////////////
    // Counts on-time samples; the first high sample reads zero.
    logic [9:0] on_cnt_reg;
    logic [9:0] on_cnt_next;
    int olp_cnt_reg;
    int olp_cnt_next;
    logic run;
    logic quiet;
    assign on_cnt_next = gate_o ? on_cnt_reg + 10'h001 : 10'h000;
    assign olp_cnt_next = (fb_above_limit_i && run) ? olp_cnt_reg + 1 : 0;
    assign run = !lockout_o && !fault_o;
    // Faults may legally cut a pulse inside blanking, so they are excluded there.
    assign quiet = !supply_ovp_i && !over_temp_i && !sense_open_i && !supply_below_lockout_i && !fb_above_limit_i;
    always_ff @(posedge sys_clk_i) on_cnt_reg <= rst_i ? 10'h000 : on_cnt_next;
    always_ff @(posedge sys_clk_i) olp_cnt_reg <= rst_i ? 0 : olp_cnt_next;

    ////////////////////////////////////////////////////////////////////////
    a_lockout_gate_off: assert property (lockout_o |-> !gate_o)
        else $error("gate high in lockout");
    a_exit_lockout: assert property (lockout_o && supply_above_exit_i && !supply_ovp_i |=> !lockout_o)
        else $error("lockout not left at exit level");
    a_fault_gate_off: assert property (fault_o |-> !gate_o)
        else $error("gate high in fault");
    a_fault_hold: assert property (fault_o && !supply_below_lockout_i |=> fault_o && $stable(fault_code_o))
        else $error("fault released early");
    a_blank_hold: assert property (gate_o && on_cnt_reg < 10'h00E && quiet |=> gate_o)
        else $error("pulse cut inside blanking");
    a_cs_ends: assert property (gate_o && on_cnt_reg >= 10'h00E && (cs_reach_fb_i || cs_reach_ss_i)
        |=> !gate_o)
        else $error("pulse not ended by sense");
    a_temp_trip: assert property (run && over_temp_i && !supply_ovp_i && !supply_below_lockout_i
        |=> fault_o && fault_code_o == 3'h3)
        else $error("over temperature not tripped");
    a_supply_ovp: assert property (run && supply_ovp_i && !supply_below_lockout_i
        |=> fault_o && fault_code_o == 3'h5)
        else $error("supply overvoltage not tripped");
    a_restart_ss: assert property ($fell(lockout_o) |-> ss_level_o == 8'h00)
        else $error("soft start not restarted");
    a_ss_rise: assert property (!lockout_o && $past(!lockout_o) |-> ss_level_o >= $past(ss_level_o))
        else $error("soft start level fell");
    a_burst_gate: assert property ($rose(gate_o) && $past(burst_o)
        |-> $past(supply_below_burst_i && fb_on_request_i))
        else $error("burst pulse without request");
    a_overload_trip: assert property (olp_cnt_reg < OLP_CYCLES + 4)
        else $error("overload not tripped");

    c_pulse: cover property ($rose(gate_o));
    c_out_ovp: cover property ($rose(fault_o) && fault_code_o == 3'h1);
    c_burst: cover property (burst_o && $rose(gate_o));
endmodule // fppc_core_assertions

bind fppc_core fppc_core_assertions #(.SS_CYCLES(SS_CYCLES), .OLP_CYCLES(OLP_CYCLES)) u_chk (.sys_clk_i, .rst_i,
    .supply_above_exit_i, .supply_below_lockout_i, .supply_ovp_i, .supply_below_burst_i, .fb_below_burst_i,
    .fb_on_request_i, .fb_above_limit_i, .cs_reach_fb_i, .cs_reach_ss_i, .sense_open_i, .over_temp_i,
    .plateau_above_i, .gate_o, .ss_level_o, .lockout_o, .burst_o, .fault_o, .fault_code_o);

/* dv/fppc_stage_model.sv */
`timescale 1ns/10ps
module fppc_stage_model
(
    // Clock and reset.
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Gate and setup.
    input wire logic gate_i,
    input wire logic [fppc_pkg::SS_LEVEL_W-1:0] ss_level_i,
    input wire logic [9:0] ramp_i,
    input wire logic ovp_en_i,
    // Comparator results.
    output logic cs_reach_fb_o,
    output logic cs_reach_ss_o,
    output logic plateau_above_o
);
    logic [9:0] on_cnt_reg;
    logic [9:0] off_cnt_reg;
    logic ring_reg;

    // The winding rings after turn-off, so an early sample sees a toggling level.
    always_ff @(posedge sys_clk_i)
    begin
        ring_reg <= rst_i ? 1'h0 : !ring_reg;
        on_cnt_reg <= (rst_i || !gate_i) ? 10'h000 : on_cnt_reg + 10'h001;
        off_cnt_reg <= (rst_i || gate_i) ? 10'h000 : off_cnt_reg + {9'h000, off_cnt_reg != 10'h3FF};
    end

    assign cs_reach_fb_o = gate_i && (on_cnt_reg + 10'h001 >= ramp_i);
    assign cs_reach_ss_o = gate_i && (on_cnt_reg + 10'h001 >= {2'h0, ss_level_i});
    assign plateau_above_o = (off_cnt_reg >= 10'h050 && off_cnt_reg < 10'h12C) ? ovp_en_i : ring_reg;
endmodule // fppc_stage_model

/* dv/fppc_core_tb_top.sv */
`timescale 1ns/10ps
module fppc_core_tb_top;
    localparam int SS_SIM = 2550;
    localparam int OLP_SIM = 500;
    logic sys_clk_i = 1'h0, rst_i = 1'h1, ovp_en = 1'h0;
    logic supply_above_exit_i = 1'h0, supply_below_lockout_i = 1'h1, supply_ovp_i = 1'h0, supply_below_burst_i = 1'h0;
    logic fb_below_burst_i = 1'h0, fb_on_request_i = 1'h0, fb_above_limit_i = 1'h0, sense_open_i = 1'h0;
    logic over_temp_i = 1'h0, prev_gate = 1'h0, prev_fault = 1'h0;
    logic cs_reach_fb_i, cs_reach_ss_i, plateau_above_i, gate_o, lockout_o, burst_o, fault_o;
    logic [fppc_pkg::SS_LEVEL_W-1:0] ss_level_o;
    logic [2:0] fault_code_o;
    logic [9:0] ramp = 10'h014;
    logic [2:0] codes[4] = '{3'h5, 3'h3, 3'h4, 3'h2};
    logic [2:0] exp_code[$];
    int exp_width[$];
    int errors = 0, compares = 0, width = 0, per = 0, cyc_n = 0, last_rise = 0, rises = 0;
    int pmin = 9999, pmax = 0, r, n0;

    fppc_core #(.SS_CYCLES(SS_SIM), .OLP_CYCLES(OLP_SIM)) dut (.sys_clk_i, .rst_i, .supply_above_exit_i,
        .supply_below_lockout_i, .supply_ovp_i, .supply_below_burst_i, .fb_below_burst_i, .fb_on_request_i,
        .fb_above_limit_i, .cs_reach_fb_i, .cs_reach_ss_i, .sense_open_i, .over_temp_i, .plateau_above_i,
        .gate_o, .ss_level_o, .lockout_o, .burst_o, .fault_o, .fault_code_o);
    fppc_stage_model u_stage (.sys_clk_i, .rst_i, .gate_i(gate_o), .ss_level_i(ss_level_o), .ramp_i(ramp),
        .ovp_en_i(ovp_en), .cs_reach_fb_o(cs_reach_fb_i), .cs_reach_ss_o(cs_reach_ss_i),
        .plateau_above_o(plateau_above_i));

    initial
    begin
        forever #10 sys_clk_i = !sys_clk_i;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected at %0t: got %0h, expected %0h", $time, seen, exp);
        end
    endtask

    function automatic logic mon(input int k);
        return (k == 0) ? lockout_o : (k == 1) ? fault_o : gate_o;
    endfunction

    task automatic wait_mon(input int k, input logic v, input int lim);
        int i;
        for (i = 0; i < lim && mon(k) !== v; i++)
            @(posedge sys_clk_i);
        if (mon(k) !== v)
        begin
            errors++;
            $display("unexpected at %0t: wait on output %0d ran out", $time, k);
            end_of_test();
        end
    endtask

    task automatic pulses(input int n);
        repeat (n)
        begin
            wait_mon(2, 1'h1, 3000);
            wait_mon(2, 1'h0, 1000);
        end
        @(posedge sys_clk_i);
    endtask

    task automatic drive(input int k, input logic v);
        case (k)
            0: supply_ovp_i <= v;
            1: over_temp_i <= v;
            2: sense_open_i <= v;
            default: fb_above_limit_i <= v;
        endcase
    endtask

    // Every start passes through lockout so the soft-start ramp is seen each time.
    task automatic power_up;
        supply_below_lockout_i <= 1'h1;
        supply_above_exit_i <= 1'h0;
        repeat (3) @(posedge sys_clk_i);
        check(lockout_o, 1'h1);
        supply_below_lockout_i <= 1'h0;
        supply_above_exit_i <= 1'h1;
        wait_mon(0, 1'h0, 4);
        check(ss_level_o < 8'h04, 1'h1);
        repeat (SS_SIM + 20) @(posedge sys_clk_i);
        check(ss_level_o, 8'hFF);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scoreboard: notes are taken off in order as pulses end and faults rise.
    always @(posedge sys_clk_i)
    begin
        cyc_n <= cyc_n + 1;
        prev_gate <= gate_o;
        prev_fault <= fault_o;
        width <= (gate_o === 1'h1) ? width + 1 : 0;
        if (gate_o === 1'h1 && prev_gate !== 1'h1)
        begin
            per <= cyc_n - last_rise;
            last_rise <= cyc_n;
            rises <= rises + 1;
        end
        if (gate_o !== 1'h1 && width > 0 && exp_width.size() > 0)
            check(width, exp_width.pop_front());
        if (fault_o === 1'h1 && prev_fault !== 1'h1)
            check(fault_code_o, (exp_code.size() > 0) ? exp_code.pop_front() : 3'h0);
    end

    initial
    begin
        void'($urandom(79607));
        repeat (16) @(posedge sys_clk_i);
        rst_i <= 1'h0;
        repeat (20) @(posedge sys_clk_i);
        check({lockout_o, gate_o, fault_o, fault_code_o}, 6'h20);
        power_up();
        pulses(1);
        repeat (16)
        begin
            pulses(1);
            check(per >= 873 && per <= 945, 1'h1);
            pmin = (per < pmin) ? per : pmin;
            pmax = (per > pmax) ? per : pmax;
        end
        check(pmax > pmin, 1'h1);
        for (int j = 0; j < 3; j++)
        begin
            r = (j == 0) ? 5 : (j == 1) ? 14 : 20 + $urandom % 60;
            ramp <= r[9:0];
            // The model trips in the r-th on cycle; blanking stretches the pulse to one cycle past it.
            exp_width.push_back((r < fppc_pkg::BLANK_CYC + 1) ? fppc_pkg::BLANK_CYC + 1 : r);
            pulses(2);
        end
        fb_below_burst_i <= 1'h1;
        fb_on_request_i <= 1'h1;
        repeat (20) @(posedge sys_clk_i);
        n0 = rises;
        repeat (5000) @(posedge sys_clk_i);
        check({burst_o, rises == n0}, 2'h3);
        supply_below_burst_i <= 1'h1;
        pulses(3);
        check(per, fppc_pkg::BURST_CYC);
        fb_below_burst_i <= 1'h0;
        supply_below_burst_i <= 1'h0;
        pulses(1);
        ovp_en <= 1'h1;
        pulses(7);
        ovp_en <= 1'h0;
        pulses(2);
        check(fault_o, 1'h0);
        exp_code.push_back(3'h1);
        ovp_en <= 1'h1;
        wait_mon(1, 1'h1, 9000);
        ovp_en <= 1'h0;
        power_up();
        fb_above_limit_i <= 1'h1;
        repeat (OLP_SIM - 50) @(posedge sys_clk_i);
        fb_above_limit_i <= 1'h0;
        @(posedge sys_clk_i);
        check(fault_o, 1'h0);
        for (int k = 0; k < 4; k++)
        begin
            power_up();
            exp_code.push_back(codes[k]);
            drive(k, 1'h1);
            wait_mon(1, 1'h1, OLP_SIM + 100);
            drive(k, 1'h0);
            repeat (40) @(posedge sys_clk_i);
            check({fault_o, gate_o}, 2'h2);
        end
        power_up();
        pulses(1);
        end_of_test();
    end
endmodule // fppc_core_tb_top
